// [src/vicu_pkg.sv]
package vicu_pkg;

	// ==========================================================
	// bus geometry
	localparam int          VICU_ADDR_W       = 12;
	localparam int          VICU_DATA_W       = 32;
	localparam int          VICU_CHANNELS     = 32;
	localparam int          VICU_PRIO_W       = 4;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [11:0] VICU_RAW_STAT_OFF  = 12'h000;
	localparam logic [11:0] VICU_ENABLE_OFF    = 12'h004;
	localparam logic [11:0] VICU_FAST_SEL_OFF  = 12'h008;
	localparam logic [11:0] VICU_FAST_STAT_OFF = 12'h00C;
	localparam logic [11:0] VICU_NORM_STAT_OFF = 12'h010;
	localparam logic [11:0] VICU_VECT_ADDR_OFF = 12'h014;
	localparam logic [11:0] VICU_DEF_ADDR_OFF  = 12'h018;
	localparam logic [11:0] VICU_A_RISE_OFF    = 12'h040;
	localparam logic [11:0] VICU_A_FALL_OFF    = 12'h044;
	localparam logic [11:0] VICU_A_EDGE_OFF    = 12'h048;
	localparam logic [11:0] VICU_A_MASK_OFF    = 12'h04C;
	localparam logic [11:0] VICU_C_RISE_OFF    = 12'h050;
	localparam logic [11:0] VICU_C_FALL_OFF    = 12'h054;
	localparam logic [11:0] VICU_C_EDGE_OFF    = 12'h058;
	localparam logic [11:0] VICU_C_MASK_OFF    = 12'h05C;
	// per-channel tables: base plus four times the channel number
	localparam logic [11:0] VICU_PRIO_BASE     = 12'h100;
	localparam logic [11:0] VICU_VECT_BASE     = 12'h200;
	localparam int          VICU_TBL_LSB       = 7;

	// ==========================================================
	// reset values
	localparam logic [31:0] VICU_WORD_RST      = 32'h0000_0000;
	localparam logic [3:0]  VICU_PRIO_RST      = 4'hF;

	// ==========================================================
	// channel that carries the merged port edge requests
	localparam int          VICU_EXT3_CH_DEF   = 17;

endpackage

// [src/vicu_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - 32 request inputs, each programmable any time as fast or vectored class.
// - fast class always wins over any vectored request.
// - fast output is the OR of all active fast requests.
// - readable word shows which fast sources are requesting now.
// - non-fast requests are vectored and carry a programmable priority level.
// - equal priority vectored requests: lowest channel number is served first.
// - normal output is the OR of all active vectored requests.
// - readable register holds the handler address of the selected request.
// - any port A or port C pin can interrupt on rise, fall or both.
// - port edge requests merge onto the external line three channel input.
module vicu_top
	import vicu_pkg::*;
#(
	parameter int PORT_A_W = 32,
	parameter int PORT_C_W = 14,
	parameter int EXT3_CH  = VICU_EXT3_CH_DEF
)
(
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst,
	// apb slave
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [VICU_ADDR_W-1:0] i_paddr,
	input  wire logic [VICU_DATA_W-1:0] i_pwdata,
	output logic      [VICU_DATA_W-1:0] o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	// peripheral request lines, same clock
	input  wire logic [31:0]            i_irq_req,
	// asynchronous port pins
	input  wire logic [PORT_A_W-1:0]    i_gpio_port_a,
	input  wire logic [PORT_C_W-1:0]    i_gpio_port_c,
	// core side
	output logic                        o_fast_interrupt_request,
	output logic                        o_normal_interrupt_request,
	output logic                        o_edge_irq
);

	// ==========================================================
	// registers
	logic [31:0]          enable_reg;
	logic [31:0]          fast_sel_reg;
	logic [31:0]          def_addr_reg;
	logic [31:0]          vect_addr_reg;
	logic [3:0]           prio_reg [VICU_CHANNELS];
	logic [31:0]          vect_reg [VICU_CHANNELS];
	logic [PORT_A_W-1:0]  a_rise_reg;
	logic [PORT_A_W-1:0]  a_fall_reg;
	logic [PORT_A_W-1:0]  a_edge_reg;
	logic [PORT_A_W-1:0]  a_mask_reg;
	logic [PORT_C_W-1:0]  c_rise_reg;
	logic [PORT_C_W-1:0]  c_fall_reg;
	logic [PORT_C_W-1:0]  c_edge_reg;
	logic [PORT_C_W-1:0]  c_mask_reg;
	logic [PORT_A_W-1:0]  a_sync1_reg;
	logic [PORT_A_W-1:0]  a_sync2_reg;
	logic [PORT_A_W-1:0]  a_prev_reg;
	logic [PORT_C_W-1:0]  c_sync1_reg;
	logic [PORT_C_W-1:0]  c_sync2_reg;
	logic [PORT_C_W-1:0]  c_prev_reg;
	logic [2:0]           arm_reg;
	logic                 fast_out_reg;
	logic                 norm_out_reg;
	logic                 edge_out_reg;
	logic [31:0]          prdata_reg;
	logic                 pslverr_reg;

	// ==========================================================
	// apb decode
	wire                  setup_rd   = i_psel & ~i_penable & ~i_pwrite;
	wire                  setup_any  = i_psel & ~i_penable;
	wire                  wr_en      = i_psel & i_penable & i_pwrite;
	wire [4:0]            tbl_idx    = i_paddr[6:2];
	wire                  word_ok    = (i_paddr[1:0] == 2'h0);
	wire                  in_prio    = word_ok
		& (i_paddr[11:VICU_TBL_LSB] == VICU_PRIO_BASE[11:VICU_TBL_LSB]);
	wire                  in_vect    = word_ok
		& (i_paddr[11:VICU_TBL_LSB] == VICU_VECT_BASE[11:VICU_TBL_LSB]);
	wire                  s_raw      = (i_paddr == VICU_RAW_STAT_OFF);
	wire                  s_en       = (i_paddr == VICU_ENABLE_OFF);
	wire                  s_fsel     = (i_paddr == VICU_FAST_SEL_OFF);
	wire                  s_fstat    = (i_paddr == VICU_FAST_STAT_OFF);
	wire                  s_nstat    = (i_paddr == VICU_NORM_STAT_OFF);
	wire                  s_vaddr    = (i_paddr == VICU_VECT_ADDR_OFF);
	wire                  s_daddr    = (i_paddr == VICU_DEF_ADDR_OFF);
	wire                  s_arise    = (i_paddr == VICU_A_RISE_OFF);
	wire                  s_afall    = (i_paddr == VICU_A_FALL_OFF);
	wire                  s_aedge    = (i_paddr == VICU_A_EDGE_OFF);
	wire                  s_amask    = (i_paddr == VICU_A_MASK_OFF);
	wire                  s_crise    = (i_paddr == VICU_C_RISE_OFF);
	wire                  s_cfall    = (i_paddr == VICU_C_FALL_OFF);
	wire                  s_cedge    = (i_paddr == VICU_C_EDGE_OFF);
	wire                  s_cmask    = (i_paddr == VICU_C_MASK_OFF);
	wire                  mapped     = s_raw | s_en | s_fsel | s_fstat | s_nstat | s_vaddr
		| s_daddr | s_arise | s_afall | s_aedge | s_amask | s_crise | s_cfall
		| s_cedge | s_cmask | in_prio | in_vect;

	// ==========================================================
	// port edge detection
	// no edges until the pin history has filled after reset
	wire                  edge_armed = arm_reg[2];
	wire [PORT_A_W-1:0]   a_evt = {PORT_A_W{edge_armed}}
		& ((a_sync2_reg & ~a_prev_reg & a_rise_reg)
		| (~a_sync2_reg & a_prev_reg & a_fall_reg));
	wire [PORT_C_W-1:0]   c_evt = {PORT_C_W{edge_armed}}
		& ((c_sync2_reg & ~c_prev_reg & c_rise_reg)
		| (~c_sync2_reg & c_prev_reg & c_fall_reg));
	wire [PORT_A_W-1:0]   a_clr = (wr_en & s_aedge) ? i_pwdata[PORT_A_W-1:0] : '0;
	wire [PORT_C_W-1:0]   c_clr = (wr_en & s_cedge) ? i_pwdata[PORT_C_W-1:0] : '0;
	// a new edge in the clearing cycle survives
	wire [PORT_A_W-1:0]   a_edge_next = (a_edge_reg & ~a_clr) | a_evt;
	wire [PORT_C_W-1:0]   c_edge_next = (c_edge_reg & ~c_clr) | c_evt;
	wire                  edge_pend = (|(a_edge_reg & a_mask_reg))
		| (|(c_edge_reg & c_mask_reg));

	// ==========================================================
	// request classification
	wire [31:0]           ext3_bit = 32'h1 << EXT3_CH;
	wire [31:0]           req_all  = i_irq_req | (edge_pend ? ext3_bit : 32'h0);
	wire [31:0]           req_act  = req_all & enable_reg;
	wire [31:0]           fast_act = req_act & fast_sel_reg;
	wire [31:0]           norm_act = req_act & ~fast_sel_reg;

	// ==========================================================
	// vectored arbitration: lower level value is more urgent
	logic [3:0]           best_prio;
	logic [4:0]           best_idx;
	logic                 best_hit;

	always_comb
	begin
		best_prio = VICU_PRIO_RST;
		best_idx  = 5'h00;
		best_hit  = 1'b0;
		for (int n = 0; n < VICU_CHANNELS; n++)
		begin
			// strict compare keeps the lower channel on a tie
			if (norm_act[n] && (!best_hit || prio_reg[n] < best_prio))
			begin
				best_prio = prio_reg[n];
				best_idx  = 5'(n);
				best_hit  = 1'b1;
			end
		end
	end

	wire [31:0]           vect_sel = best_hit ? vect_reg[best_idx] : def_addr_reg;

	// ==========================================================
	// read mux
	wire [31:0]           a_pad_edge = 32'(a_edge_reg);
	wire [31:0]           c_pad_edge = 32'(c_edge_reg);
	wire [31:0]           rd_mux =
		s_raw   ? req_all :
		s_en    ? enable_reg :
		s_fsel  ? fast_sel_reg :
		s_fstat ? fast_act :
		s_nstat ? norm_act :
		s_vaddr ? vect_addr_reg :
		s_daddr ? def_addr_reg :
		s_arise ? 32'(a_rise_reg) :
		s_afall ? 32'(a_fall_reg) :
		s_aedge ? a_pad_edge :
		s_amask ? 32'(a_mask_reg) :
		s_crise ? 32'(c_rise_reg) :
		s_cfall ? 32'(c_fall_reg) :
		s_cedge ? c_pad_edge :
		s_cmask ? 32'(c_mask_reg) :
		in_prio ? 32'(prio_reg[tbl_idx]) :
		in_vect ? vect_reg[tbl_idx] :
		32'h0000_0000;

	// ==========================================================
	// apb answer: data captured in setup, access lasts one cycle
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			prdata_reg  <= VICU_WORD_RST;
			pslverr_reg <= 1'b0;
		end
		else if (setup_any)
		begin
			prdata_reg  <= setup_rd ? rd_mux : VICU_WORD_RST;
			pslverr_reg <= ~mapped;
		end
	end

	assign o_prdata  = prdata_reg;
	assign o_pready  = i_psel & i_penable;
	assign o_pslverr = i_psel & i_penable & pslverr_reg;

	// ==========================================================
	// control registers, written at the access edge
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			enable_reg   <= VICU_WORD_RST;
			fast_sel_reg <= VICU_WORD_RST;
			def_addr_reg <= VICU_WORD_RST;
		end
		else if (wr_en)
		begin
			if (s_en)
				enable_reg <= i_pwdata;
			if (s_fsel)
				fast_sel_reg <= i_pwdata;
			if (s_daddr)
				def_addr_reg <= i_pwdata;
		end
	end

	// port A edge configuration
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			a_rise_reg <= '0;
			a_fall_reg <= '0;
			a_mask_reg <= '0;
		end
		else if (wr_en)
		begin
			if (s_arise)
				a_rise_reg <= i_pwdata[PORT_A_W-1:0];
			if (s_afall)
				a_fall_reg <= i_pwdata[PORT_A_W-1:0];
			if (s_amask)
				a_mask_reg <= i_pwdata[PORT_A_W-1:0];
		end
	end

	// port C edge configuration
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			c_rise_reg <= '0;
			c_fall_reg <= '0;
			c_mask_reg <= '0;
		end
		else if (wr_en)
		begin
			if (s_crise)
				c_rise_reg <= i_pwdata[PORT_C_W-1:0];
			if (s_cfall)
				c_fall_reg <= i_pwdata[PORT_C_W-1:0];
			if (s_cmask)
				c_mask_reg <= i_pwdata[PORT_C_W-1:0];
		end
	end

	// ==========================================================
	// per-channel priority and handler address tables
	genvar g;
	generate
		for (g = 0; g < VICU_CHANNELS; g++)
		begin : g_chan
			wire hit = wr_en & (tbl_idx == 5'(g));

			always_ff @(posedge i_clk_sys or posedge i_rst)
			begin
				if (i_rst)
				begin
					prio_reg[g] <= VICU_PRIO_RST;
					vect_reg[g] <= VICU_WORD_RST;
				end
				else
				begin
					if (hit && in_prio)
						prio_reg[g] <= i_pwdata[VICU_PRIO_W-1:0];
					if (hit && in_vect)
						vect_reg[g] <= i_pwdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// pin synchronisers and edge status
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			a_sync1_reg <= '0;
			a_sync2_reg <= '0;
			a_prev_reg  <= '0;
			a_edge_reg  <= '0;
		end
		else
		begin
			a_sync1_reg <= i_gpio_port_a;
			a_sync2_reg <= a_sync1_reg;
			a_prev_reg  <= a_sync2_reg;
			a_edge_reg  <= a_edge_next;
		end
	end

	// port C pins
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			c_sync1_reg <= '0;
			c_sync2_reg <= '0;
			c_prev_reg  <= '0;
			c_edge_reg  <= '0;
		end
		else
		begin
			c_sync1_reg <= i_gpio_port_c;
			c_sync2_reg <= c_sync1_reg;
			c_prev_reg  <= c_sync2_reg;
			c_edge_reg  <= c_edge_next;
		end
	end

	// marks the pin history as real three edges after reset
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			arm_reg <= 3'h0;
		else
			arm_reg <= {arm_reg[1:0], 1'h1};
	end

	// ==========================================================
	// core outputs
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			fast_out_reg  <= 1'b0;
			norm_out_reg  <= 1'b0;
			edge_out_reg  <= 1'b0;
			vect_addr_reg <= VICU_WORD_RST;
		end
		else
		begin
			fast_out_reg  <= |fast_act;
			norm_out_reg  <= |norm_act;
			edge_out_reg  <= edge_pend;
			vect_addr_reg <= vect_sel;
		end
	end

	assign o_fast_interrupt_request   = fast_out_reg;
	assign o_normal_interrupt_request = norm_out_reg;
	assign o_edge_irq                 = edge_out_reg;

endmodule

// [bench/vicu_top_properties.sv]
`timescale 1ns/1ps
module vicu_top_chk
	import vicu_pkg::*;
(
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [31:0] i_irq_req,
	input wire logic        o_fast_interrupt_request,
	input wire logic        o_normal_interrupt_request
);
	// ==========================================================
	// shadow of enable and class registers, taken from bus writes
	logic [31:0] en_reg;
	logic [31:0] fs_reg;
	wire logic        wr_w  = i_psel && i_penable && i_pwrite;
	wire logic        acc_w = i_psel && i_penable;
	wire logic [31:0] act_w = i_irq_req & en_reg;
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
		begin
			en_reg <= 32'h0000_0000;
			fs_reg <= 32'h0000_0000;
		end
		else if (wr_w && i_paddr == VICU_ENABLE_OFF)
			en_reg <= i_pwdata;
		else if (wr_w && i_paddr == VICU_FAST_SEL_OFF)
			fs_reg <= i_pwdata;
	// ==========================================================
	// properties
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_rdy; o_pready == acc_w; endproperty
	a_rdy: assert property (p_rdy) else $error("pready not tied to access phase");
	property p_err; o_pslverr |-> o_pready; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access phase");
	property p_misal; acc_w && i_paddr[1:0] != 2'h0 |-> o_pslverr; endproperty
	a_misal: assert property (p_misal) else $error("misaligned access not refused");
	property p_unmap; acc_w && i_paddr >= 12'h280 |-> o_pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_map; acc_w && i_paddr == VICU_ENABLE_OFF |-> !o_pslverr; endproperty
	a_map: assert property (p_map) else $error("mapped access refused");
	property p_fast; !$past(en_reg[17]) |-> o_fast_interrupt_request == $past(|(act_w & fs_reg));
	endproperty
	a_fast: assert property (p_fast) else $error("fast line wrong");
	property p_norm; !$past(en_reg[17]) |-> o_normal_interrupt_request == $past(|(act_w & ~fs_reg));
	endproperty
	a_norm: assert property (p_norm) else $error("normal line wrong");
	property p_quiet; $past(act_w) == 32'h0 && !$past(en_reg[17]) |-> !o_fast_interrupt_request;
	endproperty
	a_quiet: assert property (p_quiet) else $error("fast line without request");
endmodule
bind vicu_top vicu_top_chk u_chk (.*);

// [bench/vicu_core_model.sv]
`timescale 1ns/1ps
module vicu_core_model
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_fast_req,
	input  wire logic       i_norm_req,
	output logic      [1:0] o_taken
);
	// 2 fast taken, 1 normal taken, 0 idle; fast pre-empts normal
	always_ff @(posedge i_clk_sys)
		o_taken <= i_fast_req ? 2'h2 : (i_norm_req ? 2'h1 : 2'h0);
endmodule

// [bench/test_vectored_interrupt_controller.sv]
`timescale 1ns/1ps
module test_vectored_interrupt_controller
	import vicu_pkg::*;
;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, req = 32'h0;
	logic        pready, pslverr, fast_interrupt_request, irq, eirq;
	logic [31:0] pa = 32'h0;
	logic [13:0] pc = 14'h3FFF;
	logic [1:0]  taken;
	int          fails = 0;
	int          num_checks = 0;
	always #2 i_clk_sys = ~i_clk_sys;
	vicu_top DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_irq_req(req), .i_gpio_port_a(pa),
		.i_gpio_port_c(pc), .o_fast_interrupt_request(fast_interrupt_request),
		.o_normal_interrupt_request(irq), .o_edge_irq(eirq));
	vicu_core_model u_core (.i_clk_sys(i_clk_sys), .i_fast_req(fast_interrupt_request), .i_norm_req(irq),
		.o_taken(taken));
	// ==========================================================
	// tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// one apb transfer, then one idle cycle
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		xfer(1'b0, a, 32'h0, q, e);
		chk(s, q, x);
	endtask
	task automatic lines(input logic [3:0] x);
		tick(3);
		chk("lines", {28'h0, fast_interrupt_request, irq, taken}, {28'h0, x});
	endtask
	// ==========================================================
	// tests
	initial
	begin
		logic [31:0] q;
		logic        e;
		tick(2);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		rd("enable", VICU_ENABLE_OFF, VICU_WORD_RST);
		rd("prio", VICU_PRIO_BASE + 12'h014, {28'h0, VICU_PRIO_RST});
		xfer(1'b0, 12'h300, 32'h0, q, e);
		chk("unmapped", {q[30:0], e}, 32'h1);
		xfer(1'b1, 12'h005, 32'hFFFF_FFFF, q, e);
		chk("misaligned", {31'h0, e}, 32'h1);
		$display("test reset done");
		wr(VICU_ENABLE_OFF, 32'hFFFD_FFEF);
		wr(VICU_FAST_SEL_OFF, 32'h0000_0003);
		req <= 32'h0000_0033;
		lines(4'hE);
		rd("fast_stat", VICU_FAST_STAT_OFF, 32'h0000_0003);
		rd("norm_stat", VICU_NORM_STAT_OFF, 32'h0000_0020);
		wr(VICU_FAST_SEL_OFF, 32'h0000_0000);
		rd("norm_stat", VICU_NORM_STAT_OFF, 32'h0000_0023);
		lines(4'h5);
		$display("test class done");
		wr(VICU_ENABLE_OFF, 32'hFFFD_FFFF);
		for (int n = 0; n < 8; n++)
			wr(VICU_VECT_BASE + 12'(4 * n), 32'h0000_1000 + n);
		req <= 32'h0000_0068;
		tick(2);
		rd("vect", VICU_VECT_ADDR_OFF, 32'h0000_1003);
		wr(VICU_PRIO_BASE + 12'h018, 32'h0000_0001);
		rd("vect", VICU_VECT_ADDR_OFF, 32'h0000_1006);
		wr(VICU_FAST_SEL_OFF, 32'h0000_0040);
		rd("vect", VICU_VECT_ADDR_OFF, 32'h0000_1003);
		req <= 32'h0000_0000;
		wr(VICU_DEF_ADDR_OFF, 32'h0000_DEF0);
		rd("vect", VICU_VECT_ADDR_OFF, 32'h0000_DEF0);
		lines(4'h0);
		$display("test priority done");
		wr(VICU_ENABLE_OFF, 32'hFFFF_FFFF);
		wr(VICU_FAST_SEL_OFF, 32'h0000_0000);
		wr(VICU_A_RISE_OFF, 32'h0000_0001);
		wr(VICU_A_MASK_OFF, 32'h0000_0001);
		pa <= 32'h0000_0001;
		tick(8);
		rd("a_edge", VICU_A_EDGE_OFF, 32'h0000_0001);
		rd("norm_stat", VICU_NORM_STAT_OFF, 32'h0002_0000);
		chk("edge_irq", {31'h0, eirq}, 32'h1);
		wr(VICU_A_EDGE_OFF, 32'h0000_0001);
		tick(2);
		chk("edge_irq", {31'h0, eirq}, 32'h0);
		wr(VICU_C_FALL_OFF, 32'h0000_0004);
		pc <= 14'h3FFB;
		tick(8);
		rd("c_edge", VICU_C_EDGE_OFF, 32'h0000_0004);
		chk("edge_irq", {31'h0, eirq}, 32'h0);
		wr(VICU_C_MASK_OFF, 32'h0000_0004);
		tick(2);
		chk("edge_irq", {31'h0, eirq}, 32'h1);
		wr(VICU_C_RISE_OFF, 32'h0000_0004);
		wr(VICU_C_EDGE_OFF, 32'h0000_0004);
		rd("c_edge", VICU_C_EDGE_OFF, 32'h0000_0000);
		pc <= 14'h3FFF;
		tick(8);
		rd("c_edge", VICU_C_EDGE_OFF, 32'h0000_0004);
		chk("edge_irq", {31'h0, eirq}, 32'h1);
		$display("test edge done");
		summarize();
	end
	initial
	begin
		#20000;
		fails++;
		summarize();
	end
endmodule
